// file: core/ddtk_pkg.sv
// Shared constants for the downlink demultiplexer and tic timekeeper
// ----------------------------------------------------------------------------
// What this block does
// - Shift eight bits per stream, latch sixteen together
// - First stream lines 0-7, second 8-15
// - Optional fixed routing map by operating mode
// - Unused channel's routed line stays idle
// - Header bytes kept out of data output
// - Each header stored in memory for processor
// - Nine-bit format: header every 2.5 msec
// - Eight-bit format: 5 msec frames, 25-frame repeat
// - Eight-bit format: every bit shifted, headers still diverted
// - Output words registered on the 200 MHz clock when the formatter is ready
// - Derive 32 MHz clock, 1 Hz tic
// - Tic coincides with downlink frame start
// - UTC counter runs from maser reference
// - Tic copies UTC counter into holding register
// - Host loads UTC counter, reads held value
// - Tic on frames divisible by 400, index kept
// - Nine-bit format drops the ninth (parity) bit of every byte
// ----------------------------------------------------------------------------
package ddtk_pkg;
  // Clock rate of the block, MHz
  localparam int unsigned CLK_MHZ          = 200;
  // Index of the last data bit of each stream's byte
  localparam logic [3:0]  LAST_DATA_BIT    = 4'h7;
  // Position of the parity bit in a nine-bit byte
  localparam logic [3:0]  PARITY_BIT       = 4'h8;
  // Formatter lines driven by the block
  localparam int unsigned LINES            = 16;
  // Frames between two tics
  localparam int unsigned FRAMES_PER_TIC   = 400;
  // Header period, nine-bit format, microseconds (2.5 msec)
  localparam int unsigned HDR_PERIOD_9B_US = 2500;
  // Frame period, eight-bit format, microseconds (5 msec)
  localparam int unsigned HDR_PERIOD_8B_US = 5000;
  // Last frame number of the 25-frame eight-bit header repeat
  localparam logic [4:0]  HDR_REPEAT_LAST  = 5'h18;
  // Index of each synchronised pin
  localparam int unsigned SYN_LINK         = 0;
  localparam int unsigned SYN_I            = 1;
  localparam int unsigned SYN_Q            = 2;
  localparam int unsigned SYN_FS           = 3;
  localparam int unsigned SYN_UTC          = 4;
  localparam int unsigned SYN_N            = 5;
endpackage

// file: core/ddtk_buf.sv
// Two-entry valid/ready buffer in the data path
`timescale 1ns/1ps
module ddtk_buf #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][W-1:0] mem;   // Two slots
    logic              wptr;  // Write slot
    logic              rptr;  // Read slot
    logic [1:0]        cnt;   // Occupancy
  } ddtk_buf_st_t;
  ddtk_buf_st_t st_reg, st_next;

  assign in_ready  = (st_reg.cnt != 2'h2);
  assign out_valid = (st_reg.cnt != 2'h0);
  assign out_data  = st_reg.mem[st_reg.rptr];

  // Push and pop may happen in the same cycle
  always_comb
  begin
    st_next = st_reg;
    if (in_valid && in_ready)
    begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr             = ~st_reg.wptr;
    end
    if (out_valid && out_ready)
      st_next.rptr = ~st_reg.rptr;
    st_next.cnt = st_reg.cnt + {1'b0, (in_valid && in_ready)} - {1'b0, (out_valid && out_ready)};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // A stalled head word stays put until the receiver takes it
  a_buf_stall_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("stalled word lost or changed");
endmodule // ddtk_buf

// file: core/ddtk_hdr_mem.sv
// Header memory: one word per header byte pair, read by the processor
`timescale 1ns/1ps
module ddtk_hdr_mem #(
  parameter int unsigned AW = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic [15:0]        rd_data
);
  // Storage is an array, not part of the state struct, to stay a RAM
  logic [15:0] mem [2**AW];
  typedef struct packed {
    logic [15:0] rd;  // Registered read word
  } ddtk_mem_st_t;
  ddtk_mem_st_t st_reg, st_next;

  assign rd_data = st_reg.rd;

  always_comb
  begin
    st_next    = st_reg;
    st_next.rd = mem[rd_addr];
  end

  // Write port, no reset needed on contents
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // A written header word is held for the processor
  a_hdr_word_kept: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en |=> (mem[$past(wr_addr)] == $past(wr_data)))
    else $error("header word not stored");
endmodule // ddtk_hdr_mem

// file: core/ddtk_top.sv
// Downlink byte demultiplexer, formatter clocks and UTC tic timekeeper
`timescale 1ns/1ps
module ddtk_top
  import ddtk_pkg::*;
#(
  parameter int unsigned HDR_AW        = 4,   // Header words = 2**HDR_AW
  parameter int unsigned UTC_W         = 48,  // UTC counter width
  parameter int unsigned FMT_CLK_HALF  = 1,   // Link edges per formatter clock half
  parameter int unsigned TIC_FRAMES    = ddtk_pkg::FRAMES_PER_TIC,
  parameter int unsigned GAP_9B_CYC    = ddtk_pkg::HDR_PERIOD_9B_US * ddtk_pkg::CLK_MHZ,
  parameter int unsigned GAP_8B_CYC    = ddtk_pkg::HDR_PERIOD_8B_US * ddtk_pkg::CLK_MHZ
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               link_clk_pin,     // Demodulator data clock
  input  wire logic               data_i_pin,       // First polarization stream
  input  wire logic               second_polarization_stream,
  input  wire logic               frame_start_pin,  // Marks first bit after syncword
  input  wire logic               utc_ref_pin,      // Maser-derived UTC count clock
  input  wire logic               nine_bit_mode,    // Drop parity bits
  input  wire logic               route_en,         // Use routing map
  input  wire logic [63:0]        route_sel,        // 4-bit source per line
  input  wire logic [15:0]        chan_en,          // Lines in operation
  input  wire logic               tic_enable,       // Allow tics
  input  wire logic               utc_load,         // Host load strobe
  input  wire logic [UTC_W-1:0]   utc_load_value,
  input  wire logic               host_read_hold,   // Host reading held time
  input  wire logic [HDR_AW-1:0]  hdr_rd_addr,
  input  wire logic               fmt_ready,        // Formatter takes a word
  output logic [15:0]             hdr_rd_data,
  output logic                    hdr_done,         // Header complete pulse
  output logic [4:0]              hdr_seq,          // Frame within repeat group
  output logic [15:0]             fmt_lines,
  output logic                    fmt_valid,
  output logic                    fmt_clk_out,      // Nominal 32 MHz clock
  output logic                    fmt_tic,          // Nominal 1 Hz tic pulse
  output logic [UTC_W-1:0]        utc_latched,
  output logic [31:0]             tic_frame_index,
  output logic                    framed,
  output logic                    frame_late,
  output logic                    data_overrun
);
  import ddtk_pkg::*;

  // ------------------------------------------------------------------
  // Derived widths and the state record
  // ------------------------------------------------------------------
  localparam int unsigned MW = $clog2(TIC_FRAMES);
  localparam logic [MW-1:0] MOD_LAST = MW'(TIC_FRAMES - 1);
  localparam logic [7:0] DIV_LAST = 8'(FMT_CLK_HALF - 1);
  localparam logic [23:0] GAP9 = 24'(GAP_9B_CYC);
  localparam logic [23:0] GAP8 = 24'(GAP_8B_CYC);
  localparam logic [HDR_AW:0] HDR_LEN = (HDR_AW+1)'(2**HDR_AW);

  typedef struct packed {
    logic [SYN_N-1:0]  sync1;        // First synchroniser stage
    logic [SYN_N-1:0]  sync2;        // Second synchroniser stage
    logic              link_prev;    // For link clock edge detect
    logic              utc_prev;     // For UTC reference edge detect
    logic              framed;       // First marker seen
    logic [3:0]        bit_cnt;      // Bit within byte
    logic [7:0]        sh_i;         // First stream shifter
    logic [7:0]        sh_q;         // Second stream shifter
    logic [HDR_AW:0]   byte_cnt;     // Bytes since frame start, saturates
    logic              hdr_we;
    logic [HDR_AW-1:0] hdr_addr;
    logic [15:0]       hdr_data;
    logic              hdr_done;
    logic [4:0]        hdr_seq;
    logic              push_valid;   // Word waiting for the buffer
    logic [15:0]       push_data;
    logic              overrun;
    logic [7:0]        fdiv;         // Formatter clock divider
    logic              fmt_clk;
    logic [MW-1:0]     frame_mod;    // Frame index modulo tic interval
    logic [31:0]       frame_idx;
    logic              tic_pend;     // Snapshot waits for host release
    logic              tic_pulse;
    logic [UTC_W-1:0]  utc_cnt;
    logic [UTC_W-1:0]  utc_snap;
    logic [31:0]       idx_snap;
    logic [UTC_W-1:0]  utc_latched;
    logic [31:0]       tic_idx;
    logic [23:0]       gap;          // Cycles since last marker
    logic              frame_late;
    logic [15:0]       fmt_lines;
    logic              fmt_valid;
  } ddtk_st_t;

  ddtk_st_t st_reg, st_next;

  // Buffer and memory wires
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [15:0] buf_out_data;

  // Strobes decoded from the synchronised pins
  logic link_edge;
  logic fs_edge;
  logic utc_edge;
  assign link_edge = st_reg.sync2[SYN_LINK] && !st_reg.link_prev;
  assign fs_edge   = link_edge && st_reg.sync2[SYN_FS];
  assign utc_edge  = st_reg.sync2[SYN_UTC] && !st_reg.utc_prev;

  // ------------------------------------------------------------------
  // Line routing
  // ------------------------------------------------------------------
  // Fixed map per mode; with routing on, disabled lines driven low so they carry nothing
  function automatic logic [15:0] route_word(input logic [15:0] w, input logic [63:0] sel,
                                             input logic en, input logic [15:0] chan);
    logic [15:0] r;
    r = w;
    if (en)
    begin
      for (int k = 0; k < LINES; k++)
        r[k] = w[sel[4*k +: 4]] && chan[k];
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  ni;
    logic [7:0]  nq;
    logic [15:0] word;
    logic        pushed;    // Fresh word loaded for the buffer this cycle
    logic        late_now;  // Frame period exceeded
    ni      = st_reg.sh_i;
    nq      = st_reg.sh_q;
    word    = '0;
    pushed  = 1'b0;
    late_now = st_reg.framed && (st_reg.gap >= (nine_bit_mode ? GAP9 : GAP8));
    st_next = st_reg;
    st_next.sync1      = {utc_ref_pin, frame_start_pin, second_polarization_stream,
                          data_i_pin, link_clk_pin};
    st_next.sync2      = st_reg.sync1;
    st_next.link_prev  = st_reg.sync2[SYN_LINK];
    st_next.utc_prev   = st_reg.sync2[SYN_UTC];
    st_next.hdr_we     = 1'b0;
    st_next.hdr_done   = 1'b0;
    st_next.tic_pulse  = 1'b0;
    st_next.fmt_valid  = 1'b0;

    // UTC counter on the maser reference, host load wins
    if (utc_load)
      st_next.utc_cnt = utc_load_value;
    else if (utc_edge)
      st_next.utc_cnt = st_reg.utc_cnt + UTC_W'(1);

    // Frame gap watch against the expected frame period
    if (st_reg.framed && st_reg.gap != 24'hffffff)
      st_next.gap = st_reg.gap + 24'h1;
    if (late_now)
      st_next.frame_late = 1'b1;

    if (link_edge)
    begin
      // Formatter clock divided from link clock edges
      if (st_reg.fdiv == DIV_LAST)
      begin
        st_next.fdiv    = '0;
        st_next.fmt_clk = ~st_reg.fmt_clk;
      end
      else
        st_next.fdiv = st_reg.fdiv + 8'h1;

      // Frame marker realigns byte assembly and frame counters, not the clock divider
      if (fs_edge)
      begin
        st_next.framed     = 1'b1;
        st_next.bit_cnt    = '0;
        st_next.byte_cnt   = '0;
        st_next.gap        = '0;
        st_next.frame_late = late_now;               // A late marker keeps the flag
        st_next.frame_idx  = st_reg.framed ? st_reg.frame_idx + 32'h1 : '0;
        st_next.frame_mod  = (!st_reg.framed || st_reg.frame_mod == MOD_LAST) ? '0
                             : st_reg.frame_mod + MW'(1);
        st_next.hdr_seq    = (!st_reg.framed || st_reg.hdr_seq == HDR_REPEAT_LAST) ? '0
                             : st_reg.hdr_seq + 5'h1;
        // Tic only on frames whose index is a multiple of the interval
        if (tic_enable && (!st_reg.framed || st_reg.frame_mod == MOD_LAST))
        begin
          st_next.tic_pulse = 1'b1;
          st_next.tic_pend  = 1'b1;
          st_next.utc_snap  = st_next.utc_cnt;
          st_next.idx_snap  = st_next.frame_idx;
        end
      end

      // Assemble bytes once framed; the marker bit is bit 0
      if (st_reg.framed || fs_edge)
      begin
        if (nine_bit_mode && !fs_edge && st_reg.bit_cnt == PARITY_BIT)
          st_next.bit_cnt = '0;
        else
        begin
          ni = {st_reg.sync2[SYN_I], st_reg.sh_i[7:1]};
          nq = {st_reg.sync2[SYN_Q], st_reg.sh_q[7:1]};
          st_next.sh_i = ni;
          st_next.sh_q = nq;
          if (st_next.bit_cnt == LAST_DATA_BIT)
          begin
            // Eight-bit format wraps here, nine-bit goes on to parity
            st_next.bit_cnt = nine_bit_mode ? PARITY_BIT : '0;
            word = {nq, ni};
            if (st_next.byte_cnt < HDR_LEN)
            begin
              st_next.hdr_we   = 1'b1;
              st_next.hdr_addr = st_next.byte_cnt[HDR_AW-1:0];
              st_next.hdr_data = word;
              st_next.hdr_done = (st_next.byte_cnt == HDR_LEN - (HDR_AW+1)'(1));
              st_next.byte_cnt = st_next.byte_cnt + (HDR_AW+1)'(1);
            end
            else
            begin
              // A word still waiting means the formatter fell behind
              if (st_reg.push_valid && !buf_in_ready)
                st_next.overrun = 1'b1;
              st_next.push_valid = 1'b1;
              pushed             = 1'b1;
              st_next.push_data  = route_word(word, route_sel, route_en, chan_en);
            end
          end
          else
            st_next.bit_cnt = st_next.bit_cnt + 4'h1;
        end
      end
    end

    // Hand word to buffer; held until taken, a word loaded now stays pending
    if (st_reg.push_valid && buf_in_ready && !pushed)
      st_next.push_valid = 1'b0;

    // Release the snapshot only when the host is not reading
    if (st_reg.tic_pend && !host_read_hold)
    begin
      st_next.utc_latched = st_reg.utc_snap;
      st_next.tic_idx     = st_reg.idx_snap;
      st_next.tic_pend    = st_next.tic_pulse;
    end

    // Drain the buffer toward the formatter
    if (buf_out_valid && fmt_ready)
    begin
      st_next.fmt_lines = buf_out_data;
      st_next.fmt_valid = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------
  ddtk_buf #(.W(16)) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (st_reg.push_valid),
    .in_data   (st_reg.push_data),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (fmt_ready)
  );

  ddtk_hdr_mem #(.AW(HDR_AW)) u_hdr (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (st_reg.hdr_we),
    .wr_addr (st_reg.hdr_addr),
    .wr_data (st_reg.hdr_data),
    .rd_addr (hdr_rd_addr),
    .rd_data (hdr_rd_data)
  );

  // Outputs straight from state flops
  assign hdr_done        = st_reg.hdr_done;
  assign hdr_seq         = st_reg.hdr_seq;
  assign fmt_lines       = st_reg.fmt_lines;
  assign fmt_valid       = st_reg.fmt_valid;
  assign fmt_clk_out     = st_reg.fmt_clk;
  assign fmt_tic         = st_reg.tic_pulse;
  assign utc_latched     = st_reg.utc_latched;
  assign tic_frame_index = st_reg.tic_idx;
  assign framed          = st_reg.framed;
  assign frame_late      = st_reg.frame_late;
  assign data_overrun    = st_reg.overrun;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_idle_unframed: assert property (@(posedge clk) disable iff (!rst_b)
    !st_reg.framed |-> (!st_reg.push_valid && !st_reg.hdr_we && !st_reg.tic_pulse))
    else $error("activity before first frame marker");

  a_parity_dropped: assert property (@(posedge clk) disable iff (!rst_b)
    (link_edge && !fs_edge && nine_bit_mode && st_reg.bit_cnt == PARITY_BIT)
      |=> ($stable(st_reg.sh_i) && st_reg.bit_cnt == 4'h0))
    else $error("parity bit entered the shifter");

  a_header_stored: assert property (@(posedge clk) disable iff (!rst_b)
    (link_edge && st_reg.framed && !fs_edge && !nine_bit_mode
     && st_reg.bit_cnt == LAST_DATA_BIT && st_reg.byte_cnt < HDR_LEN)
      |=> (st_reg.hdr_we && $stable(st_reg.push_data)))
    else $error("header byte not diverted");

  a_tic_on_frame: assert property (@(posedge clk) disable iff (!rst_b)
    st_reg.tic_pulse |-> $past(fs_edge) ##1 !st_reg.tic_pulse)
    else $error("tic not aligned to frame start");

  a_tic_latches: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg.tic_pend && !host_read_hold)
      |=> (st_reg.utc_latched == $past(st_reg.utc_snap)))
    else $error("held time not updated at tic");

  a_hold_stable: assert property (@(posedge clk) disable iff (!rst_b)
    host_read_hold |=> $stable(st_reg.utc_latched) && $stable(st_reg.tic_idx))
    else $error("held time changed during host read");

  a_utc_loaded: assert property (@(posedge clk) disable iff (!rst_b)
    utc_load |=> (st_reg.utc_cnt == $past(utc_load_value)))
    else $error("UTC load ignored");

  a_fmt_clk_div: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_reg.fmt_clk) |-> $past(link_edge))
    else $error("formatter clock moved without a link edge");

  a_line_unused: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg.push_valid && route_en && $stable(chan_en) && $stable(route_en))
      |-> ((st_reg.push_data & ~chan_en) == 16'h0000))
    else $error("disabled line carries data");
endmodule // ddtk_top

// file: sim/ddtk_fmt_model.sv
// Formatter model: takes words with random stalls and keeps a recorder clock
`timescale 1ns/1ps
module ddtk_fmt_model (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   fmt_tic,
  output logic        fmt_ready,
  output logic [31:0] rec_clk
);
  // ----------------------------------------
  // Acceptance: short random stalls
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (!rst_b)
      fmt_ready <= 1'b0;
    else
      fmt_ready <= ($urandom % 4) != 0;
  end
  // Recorder clock starts at zero and steps once per tic
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rec_clk <= 32'h0;
    else if (fmt_tic === 1'b1)
      rec_clk <= rec_clk + 32'h1;
  end
endmodule // ddtk_fmt_model

// file: sim/downlink_demux_and_tic_timekeeper_tb.sv
// Self-checking bench for the downlink demultiplexer and tic timekeeper
`timescale 1ns/1ps
module downlink_demux_and_tic_timekeeper_tb;
  import ddtk_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, lk = 1'b0, di = 1'b0, dq = 1'b0;
  logic        fs = 1'b0, ur = 1'b0, nine, ren, ten, uld, hold, fr, fco_q;
  logic [63:0] rsel;
  logic [15:0] chen, hrd, fl, exq[$], hexp[16];
  logic [47:0] ulv, ul, v;
  logic [3:0]  hra;
  logic [31:0] tfi, rec_clk;
  logic [4:0]  hseq;
  logic        hdone, fv, fco, tic, framed, late, ovr;
  int          err_count = 0, checked = 0, rises = 0, togs = 0, dones = 0;
  always #2.5 clk = ~clk;
  ddtk_top #(.TIC_FRAMES(2), .GAP_9B_CYC(3000), .GAP_8B_CYC(6000)) DUT (
    .clk(clk), .rst_b(rst_b), .link_clk_pin(lk), .data_i_pin(di),
    .second_polarization_stream(dq), .frame_start_pin(fs), .utc_ref_pin(ur),
    .nine_bit_mode(nine), .route_en(ren), .route_sel(rsel), .chan_en(chen),
    .tic_enable(ten), .utc_load(uld), .utc_load_value(ulv), .host_read_hold(hold),
    .hdr_rd_addr(hra), .fmt_ready(fr), .hdr_rd_data(hrd), .hdr_done(hdone),
    .hdr_seq(hseq), .fmt_lines(fl), .fmt_valid(fv), .fmt_clk_out(fco),
    .fmt_tic(tic), .utc_latched(ul), .tic_frame_index(tfi), .framed(framed),
    .frame_late(late), .data_overrun(ovr));
  ddtk_fmt_model FMT (.clk(clk), .rst_b(rst_b), .fmt_tic(tic), .fmt_ready(fr),
    .rec_clk(rec_clk));
  // ----------------------------------------
  // Compare, verdict
  // ----------------------------------------
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %0t word %h expected %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic chk_v(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %0t value %h expected %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Expected line map: routing only when enabled, idle channels low
  function automatic logic [15:0] route(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    if (ren)
      for (int k = 0; k < 16; k++)
        r[k] = chen[k] ? w[rsel[4*k +: 4]] : 1'b0;
    return r;
  endfunction
  // One link bit; pins settle a half period before the rising edge
  task automatic sbit(input logic i, input logic q, input logic m);
    lk = 1'b0;
    di = i;
    dq = q;
    fs = m;
    #24 lk = 1'b1;
    rises++;
    #24;
  endtask
  task automatic upulse(input int n);
    repeat (n)
    begin
      #20 ur = 1'b1;
      #20 ur = 1'b0;
    end
  endtask
  // Frame: 16 header bytes then nd data bytes per stream, LSB first
  task automatic frame(input int nd);
    logic [7:0] bi, bq;
    for (int b = 0; b < 16 + nd; b++)
    begin
      bi = 8'($urandom);
      bq = 8'($urandom);
      if (b < 16)
        hexp[b] = {bq, bi};
      else
        exq.push_back(route({bq, bi}));
      for (int n = 0; n < (nine ? 9 : 8); n++)
        sbit(n < 8 ? bi[n] : 1'($urandom), n < 8 ? bq[n] : 1'($urandom), b == 0 && n == 0);
    end
    lk = 1'b0;  // Link clock stands still; data lines scramble
    di = ~di;
    dq = ~dq;
    fs = 1'b0;
    repeat (30) @(negedge clk);
    for (int a = 0; a < 16; a++)
    begin
      hra = 4'(a);
      repeat (2) @(negedge clk);
      chk_w(hrd, hexp[a]);
    end
  endtask
  // Formatter words, formatter clock toggles, header completions
  always @(negedge clk)
  begin
    fco_q <= fco;
    if (rst_b && fco_q !== fco)
      togs++;
    if (hdone === 1'b1)
      dones++;
    if (fv === 1'b1)
      chk_w(fl, exq.size() ? exq.pop_front() : 16'hxxxx);
  end
  initial
  begin
    #300000;
    err_count++;
    test_done;
  end
  initial
  begin
    void'($urandom(22));
    {nine, ren, rsel, chen, uld, ulv, hold, hra} = '0;
    ten = 1'b1;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk_v({fv, tic, framed}, 0);
    v = {16'($urandom), 32'($urandom)};
    ulv = v;
    uld = 1'b1;
    @(negedge clk);
    uld = 1'b0;
    upulse(3);
    frame(4);
    chk_v(ul, v + 3);
    chk_v(tfi, 0);
    chk_v(rec_clk, 1);
    chk_v(hseq, 0);
    nine = 1'b1;
    frame(4);
    chk_v(tfi, 0);
    chk_v(hseq, 1);
    nine = 1'b0;
    ren = 1'b1;
    chen = 16'($urandom);
    for (int k = 0; k < 16; k++)
      rsel[4*k +: 4] = 4'(15 - k);
    hold = 1'b1;
    upulse(2);
    frame(4);
    chk_v(ul, v + 3);
    hold = 1'b0;
    repeat (5) @(negedge clk);
    chk_v(ul, v + 5);
    chk_v(tfi, 2);
    chk_v(rec_clk, 2);
    chk_v(exq.size(), 0);
    chk_v(togs, rises);
    chk_v(dones, 3);
    chk_v(ovr, 0);
    chk_v(hseq, 2);
    chk_v({framed, late}, 2'b10);
    repeat (3100) @(negedge clk);
    chk_v(late, 0);
    repeat (1500) @(negedge clk);
    chk_v(late, 1);
    test_done;
  end
endmodule // downlink_demux_and_tic_timekeeper_tb
